/* File: rtl/sfr_pkg.sv */
// constants and types for the serial flash array read front end
//
// Overview of operation
// - opcode 0Bh, three address bytes, one dummy byte
// - 528-byte pages: 13-bit page, 10-bit offset
// - 512-byte pages: 13-bit page, 9-bit offset
// - after dummies every clock shifts next data bit
// - opcode 03h, address, data follows with no dummies
// - opcode 01h, address, data follows with no dummies
// - opcode D2h, address, four dummies, then data
// - page end continues at next page, no gap
// - array end wraps to first page, no gap
// - page read wraps within the same page
// - select rising ends read, output floats
// - reads use main array, buffers untouched
package sfr_pkg;

  // ***************************************************************
  // command set
  // ***************************************************************
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_SLOW_READ = 8'h03;
  localparam logic [7:0] OP_LOW_POWER_READ = 8'h01;
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;

  // dummy bytes after the address, per opcode
  localparam logic [2:0] DUMMY_NONE = 3'h0;
  localparam logic [2:0] DUMMY_FAST = 3'h1;
  localparam logic [2:0] DUMMY_PAGE = 3'h4;

  // ***************************************************************
  // framing and address layout
  // ***************************************************************
  localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h17;
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 13;
  localparam int OFS_W = 10;
  localparam int STD_OFS_LSB = 0;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam logic [OFS_W-1:0] STD_LAST_BYTE = 10'h20F;
  localparam logic [OFS_W-1:0] BIN_LAST_BYTE = 10'h1FF;
  localparam logic [OFS_W-1:0] BIN_OFS_MASK = 10'h1FF;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [2:0] PIN_SYNC_RST = 3'h2;  // {sck, cs_n, si}: deselected
  localparam logic [2:0] BIT_IDX_RST = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_ADDR = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA = 3'b100,
    ST_IGNORE = 3'b101
  } sfr_state_t;

endpackage

/* File: rtl/sfr_sync.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sfr_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

/* File: rtl/sfr_array_read.sv */
// array read command front end of a serial flash, on the system clock with sck oversampled through a synchroniser
`timescale 1ns/1ps
module sfr_array_read
  import sfr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic page_bin,
  output logic so,
  output logic so_oe,
  output logic arr_rd,
  output logic [PAGE_W-1:0] arr_page,
  output logic [OFS_W-1:0] arr_ofs,
  input wire logic [7:0] arr_data,
  output logic read_active
);

  // ***************************************************************
  // pin synchronisation and serial clock edges
  // ***************************************************************
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic sck_q;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;

  // all three pins share one synchroniser so their skew stays equal
  sfr_sync #(
    .WIDTH(3),
    .RST_VAL(PIN_SYNC_RST)
  ) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in({sck, cs_n, si}),
    .sync_out({sck_s, cs_n_s, si_s})
  );

  // previous synchronised level for edge finding
  always_comb begin
    sck_d = sck_s;
  end

  // reset low to match the idle level of a mode 0 clock, so no false edge follows reset
  always_ff @(posedge clock) begin
    if (srst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck_d;
    end
  end

  // edges only count while selected, so mode 3 idle-high is harmless
  assign sck_rise = sck_s & ~sck_q & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_q & ~cs_n_s;

  // ***************************************************************
  // command, address and dummy sequencing
  // ***************************************************************
  // framing state and header shift register
  sfr_state_t state_q;
  sfr_state_t state_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [ADDR_W-2:0] sh_q;
  logic [ADDR_W-2:0] sh_d;
  logic [2:0] dummy_q;
  logic [2:0] dummy_d;
  // page wrap mode, array pointer and fetch strobe
  logic wrap_page_q;
  logic wrap_page_d;
  logic [PAGE_W-1:0] page_q;
  logic [PAGE_W-1:0] page_d;
  logic [OFS_W-1:0] ofs_q;
  logic [OFS_W-1:0] ofs_d;
  logic rd_q;
  logic rd_d;
  // header fields decoded from the shift register
  logic [7:0] opcode;
  logic [ADDR_W-1:0] addr;
  logic [OFS_W-1:0] last_byte;
  logic [OFS_W-1:0] start_ofs;
  logic [PAGE_W-1:0] start_page;
  logic [5:0] dummy_last;
  logic [2:0] bit_q;

  // complete words include the bit arriving on this rising edge
  assign opcode = {sh_q[6:0], si_s};
  assign addr = {sh_q, si_s};
  assign last_byte = page_bin ? BIN_LAST_BYTE : STD_LAST_BYTE;
  assign dummy_last = 6'({dummy_q, 3'b000} - 6'h01);

  // address split depends on the page size in use
  always_comb begin
    if (page_bin) begin
      start_page = addr[BIN_PAGE_LSB +: PAGE_W];
      start_ofs = addr[STD_OFS_LSB +: OFS_W] & BIN_OFS_MASK;
    end else begin
      start_page = addr[STD_PAGE_LSB +: PAGE_W];
      start_ofs = addr[STD_OFS_LSB +: OFS_W];
    end
  end

  // one next-state process for the whole framing and the array pointer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    dummy_d = dummy_q;
    wrap_page_d = wrap_page_q;
    page_d = page_q;
    ofs_d = ofs_q;
    rd_d = 1'b0;
    // shift on every rising edge; only the framing decides what is used
    if (sck_rise) begin
      sh_d = addr[ADDR_W-2:0];
    end
    if (cs_n_s) begin
      // deselect abandons whatever was in progress
      state_d = ST_IDLE;
      cnt_d = '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // selection seen: start counting opcode bits
          state_d = ST_CMD;
          cnt_d = '0;
        end
        ST_CMD: begin
          if (sck_rise) begin
            // the eighth rising edge completes the opcode
            if (cnt_q == OPCODE_LAST_BIT) begin
              cnt_d = '0;
              state_d = ST_ADDR;
              wrap_page_d = 1'b0;
              if (opcode == OP_FAST_READ) begin
                dummy_d = DUMMY_FAST;
              end else if (opcode == OP_SLOW_READ) begin
                dummy_d = DUMMY_NONE;
              end else if (opcode == OP_LOW_POWER_READ) begin
                dummy_d = DUMMY_NONE;
              end else if (opcode == OP_PAGE_READ) begin
                dummy_d = DUMMY_PAGE;
                wrap_page_d = 1'b1;
              end else begin
                // opcodes outside this block leave the output floating
                state_d = ST_IGNORE;
              end
            end else begin
              cnt_d = 6'(cnt_q + 6'h01);
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            if (cnt_q == ADDR_LAST_BIT) begin
              cnt_d = '0;
              page_d = start_page;
              // an offset past the page end is clamped rather than wrapped
              ofs_d = (start_ofs > last_byte) ? last_byte : start_ofs;
              if (dummy_q == DUMMY_NONE) begin
                // first byte must be ready by the very next falling edge
                state_d = ST_DATA;
                rd_d = 1'b1;
              end else begin
                state_d = ST_DUMMY;
              end
            end else begin
              cnt_d = 6'(cnt_q + 6'h01);
            end
          end
        end
        ST_DUMMY: begin
          // dummy bits are counted, their values are ignored
          if (sck_rise) begin
            if (cnt_q == dummy_last) begin
              cnt_d = '0;
              state_d = ST_DATA;
              rd_d = 1'b1;
            end else begin
              cnt_d = 6'(cnt_q + 6'h01);
            end
          end
        end
        ST_DATA: begin
          // fetch the next byte while its predecessor's last bit leaves
          if (sck_fall && bit_q == 3'h0) begin
            rd_d = 1'b1;
            if (ofs_q >= last_byte) begin
              ofs_d = '0;
              if (!wrap_page_q) begin
                page_d = 13'(page_q + 13'h0001);
              end
            end else begin
              ofs_d = 10'(ofs_q + 10'h001);
            end
          end
        end
        ST_IGNORE: begin
          // refused command: deselect is the only way out
          state_d = ST_IGNORE;
        end
        default: begin
          // illegal codes fall back to idle
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // framing and pointer registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      dummy_q <= DUMMY_NONE;
      wrap_page_q <= 1'b0;
      page_q <= '0;
      ofs_q <= '0;
      rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      dummy_q <= dummy_d;
      wrap_page_q <= wrap_page_d;
      page_q <= page_d;
      ofs_q <= ofs_d;
      rd_q <= rd_d;
    end
  end

  // ***************************************************************
  // array read port
  // ***************************************************************
  // only a read port exists, so no buffer or array content can change
  assign arr_rd = rd_q;
  assign arr_page = page_q;
  assign arr_ofs = ofs_q;

  // ***************************************************************
  // output shifter
  // ***************************************************************
  // fetch pipeline and serial output registers
  logic ld_q;
  logic ld_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  logic [2:0] bit_d;
  logic so_q;
  logic so_d;
  logic oe_q;
  logic oe_d;

  // byte returns one cycle after the read strobe; a serial half period
  // is many clock cycles, so it always lands before the next fall
  always_comb begin
    ld_d = rd_q;
    byte_d = ld_q ? arr_data : byte_q;
    bit_d = bit_q;
    so_d = so_q;
    if (state_q != ST_DATA || state_d != ST_DATA) begin
      // low on both sides of the data phase, so deselect never leaves
      // a stale bit on so once the driver lets go
      bit_d = BIT_IDX_RST;
      so_d = 1'b0;
    end else if (sck_fall) begin
      // msb first, one bit per falling edge, no gap between bytes
      so_d = byte_q[bit_q];
      bit_d = 3'(bit_q - 3'h1);
    end
    // the driver releases on the same cycle deselect is seen
    oe_d = (state_d == ST_DATA);
  end

  // so and so_oe fall together on deselect
  always_ff @(posedge clock) begin
    if (srst) begin
      ld_q <= 1'b0;
      byte_q <= '0;
      bit_q <= BIT_IDX_RST;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ld_q <= ld_d;
      byte_q <= byte_d;
      bit_q <= bit_d;
      so_q <= so_d;
      oe_q <= oe_d;
    end
  end

  // data and enable come straight from flip-flops
  assign so = so_q;
  assign so_oe = oe_q;
  assign read_active = oe_q;

endmodule

/* File: verif/sfr_array_read_props.sv */
// assertion checker for the array read front end
`timescale 1ns/1ps
module sfr_array_read_props
  import sfr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic page_bin,
  input wire logic so,
  input wire logic so_oe,
  input wire logic arr_rd,
  input wire logic [PAGE_W-1:0] arr_page,
  input wire logic [OFS_W-1:0] arr_ofs,
  input wire logic [7:0] arr_data,
  input wire logic read_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ***************************************************************
  // output framing and array strobes
  // ***************************************************************
  oe_mirror_a: assert property (read_active == so_oe) else $error("read_active differs from so_oe");
  so_quiet_a: assert property (!so_oe |-> so == 1'b0) else $error("so not low while undriven");
  desel_end_a: assert property ($rose(cs_n) |-> ##[1:6] !so_oe) else $error("so_oe late after deselect");
  cs_idle_a: assert property (cs_n [*6] |-> !so_oe && !arr_rd) else $error("activity while deselected");
  rd_spacing_a: assert property (arr_rd |=> !arr_rd [*8]) else $error("array strobes too close");
  first_rd_a: assert property ($rose(so_oe) |-> ##[0:2] arr_rd) else $error("no fetch at data start");
  // start offset beyond the page end is never presented to the array
  ofs_range_a: assert property (arr_rd |-> arr_ofs <= (page_bin ? 10'h1FF : 10'h20F))
    else $error("offset beyond page end");
  so_edge_a: assert property (so_oe && $changed(so) |-> !sck && !$past(sck, 2))
    else $error("so moved off a falling edge");
endmodule

bind sfr_array_read sfr_array_read_props props_u (.clock(clock), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si),
  .page_bin(page_bin), .so(so), .so_oe(so_oe), .arr_rd(arr_rd), .arr_page(arr_page), .arr_ofs(arr_ofs),
  .arr_data(arr_data), .read_active(read_active));

/* File: verif/sfr_array_model.sv */
// main array store model answering read strobes one cycle later
`timescale 1ns/1ps
module sfr_array_model
  import sfr_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic arr_rd,
  input wire logic [PAGE_W-1:0] arr_page,
  input wire logic [OFS_W-1:0] arr_ofs,
  output logic [7:0] arr_data
);
  // byte holds only the cycle after the strobe, then churns so a late sample shows
  always_ff @(posedge clock) begin
    if (srst) arr_data <= 8'h5A;
    else if (arr_rd) arr_data <= arr_ofs[7:0] ^ arr_page[7:0] ^ {arr_page[12:8], 1'b0, arr_ofs[9:8]};
    else arr_data <= ~arr_data;
  end
endmodule

/* File: verif/tb_sfr_array_read.sv */
// self-checking bench for the array read front end
`timescale 1ns/1ps
module tb_sfr_array_read;
  import sfr_pkg::*;
  logic clock = 0, srst = 1, sck = 0, cs_n = 1, si = 0, page_bin = 0;
  logic so, so_oe, arr_rd, read_active;
  logic [PAGE_W-1:0] arr_page;
  logic [OFS_W-1:0] arr_ofs;
  logic [7:0] arr_data;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  always #4 clock = ~clock;
  sfr_array_read dut_u (.clock(clock), .srst(srst), .sck(sck), .cs_n(cs_n), .si(si), .page_bin(page_bin),
    .so(so), .so_oe(so_oe), .arr_rd(arr_rd), .arr_page(arr_page), .arr_ofs(arr_ofs), .arr_data(arr_data),
    .read_active(read_active));
  sfr_array_model mem_u (.clock(clock), .srst(srst), .arr_rd(arr_rd), .arr_page(arr_page), .arr_ofs(arr_ofs),
    .arr_data(arr_data));
  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: six commands need about 8k cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one mode 0 link bit: 160 ns period, so sampled just before the rise
  task automatic xbit(input logic v, output logic s);
    si <= v;
    tick(10);
    s = so;
    sck <= 1'b1;
    tick(10);
    sck <= 1'b0;
  endtask
  task automatic send(input logic [63:0] v, input int n);
    logic s;
    for (int i = n - 1; i >= 0; i--) xbit(v[i], s);
  endtask
  function automatic logic [7:0] exp_byte(input logic [12:0] p, input logic [9:0] o);
    return o[7:0] ^ p[7:0] ^ {p[12:8], 1'b0, o[9:8]};
  endfunction
  // full command, a few bytes, then deselect in mid-byte
  task automatic run_cmd(input logic [7:0] op, input logic pb, input logic [12:0] pg, input logic [9:0] of,
    input int dum, input int nb, input logic same_pg);
    logic [23:0] a;
    logic [7:0] b;
    logic s;
    a = pb ? {2'b0, pg, of[8:0]} : {1'b0, pg, of};
    page_bin <= pb;
    cs_n <= 1'b0;
    send({op, a}, 32);
    send(64'h0, dum);
    check("so_oe in data", {7'h0, so_oe}, 8'h01);
    check("read_active in data", {7'h0, read_active}, 8'h01);
    for (int k = 0; k < nb; k++) begin
      for (int i = 7; i >= 0; i--) begin
        xbit(1'b0, s);
        b[i] = s;
      end
      check("data byte", b, exp_byte(pg, of));
      if (of == (pb ? 10'h1FF : 10'h20F)) begin
        of = 10'h000;
        if (!same_pg) pg++;
      end else of++;
    end
    xbit(1'b1, s);
    xbit(1'b0, s);
    tick(10);
    cs_n <= 1'b1;
    tick(8);
    check("so_oe after deselect", {7'h0, so_oe}, 8'h00);
    check("so after deselect", {7'h0, so}, 8'h00);
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_fast();
    run_cmd(OP_FAST_READ, 1'b0, 13'h0005, 10'h20E, 8, 3, 1'b0);
  endtask
  task automatic t_slow();
    run_cmd(OP_SLOW_READ, 1'b1, 13'h1FFF, 10'h1FE, 0, 3, 1'b0);
  endtask
  task automatic t_low_power();
    run_cmd(OP_LOW_POWER_READ, 1'b0, 13'h1FFF, 10'h20F, 0, 2, 1'b0);
  endtask
  task automatic t_page();
    run_cmd(OP_PAGE_READ, 1'b1, 13'h0A53, 10'h1FF, 32, 2, 1'b1);
    run_cmd(OP_PAGE_READ, 1'b0, 13'h0123, 10'h20F, 32, 2, 1'b1);
  endtask
  // unknown opcode stays silent for the whole selection
  task automatic t_refused();
    cs_n <= 1'b0;
    send({8'hA5, 24'h000010, 32'h0}, 64);
    check("so_oe unknown op", {7'h0, so_oe}, 8'h00);
    cs_n <= 1'b1;
    tick(8);
  endtask
  initial begin
    tick(3);
    srst <= 1'b0;
    tick(6);
    t_fast();
    t_refused();
    t_slow();
    t_low_power();
    t_page();
    tally_and_finish();
  end
endmodule
